// File: core/uc_pkg.sv
// constants, types and shared frame arithmetic for the serial core
package uc_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] UC_ADR_DATA = 3'h0;
  localparam logic [2:0] UC_ADR_STAT = 3'h1;
  localparam logic [2:0] UC_ADR_CTRL = 3'h2;
  localparam logic [2:0] UC_ADR_FMT = 3'h3;
  localparam logic [2:0] UC_ADR_BAUDL = 3'h4;
  localparam logic [2:0] UC_ADR_BAUDH = 3'h5;
  localparam logic [2:0] UC_ADR_MODE = 3'h6;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int UC_C_TXEN = 0;
  localparam int UC_C_RXEN = 1;
  localparam int UC_C_DBL = 2;
  localparam int UC_C_COMPAT = 3;
  localparam int UC_C_TX9 = 4;
  localparam int UC_C_IE_TXC = 5;
  localparam int UC_C_IE_TXE = 6;
  localparam int UC_C_IE_RXC = 7;
  localparam int UC_F_POL = 3;
  localparam int UC_F_ODD = 4;
  localparam int UC_F_PAR = 5;
  localparam int UC_F_STOP2 = 6;
  localparam int UC_F_SYNC = 7;
  localparam int UC_S_TXC = 4;
  localparam int UC_M_MASTER = 0;
  localparam int UC_E_FE = 9;
  localparam int UC_E_DOR = 10;
  localparam int UC_E_PE = 11;
  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] UC_CTRL_RST = 8'h00;
  localparam logic [7:0] UC_FMT_RST = 8'h03;
  localparam logic [7:0] UC_MODE_RST = 8'h00;
  localparam logic [11:0] UC_BAUD_RST = 12'h000;
  localparam logic [2:0] UC_SIZE_9 = 3'h7;
  localparam logic [3:0] UC_NORM_LAST = 4'hF;
  localparam logic [3:0] UC_NORM_MID = 4'h7;
  localparam logic [3:0] UC_DBL_LAST = 4'h7;
  localparam logic [3:0] UC_DBL_MID = 4'h3;
  localparam logic [1:0] UC_DEPTH = 2'h2;
  localparam logic [1:0] UC_DEPTH_COMPAT = 2'h1;

  typedef enum logic [1:0] {UC_RX_IDLE, UC_RX_START, UC_RX_DATA} uc_rx_t;

  // size code to data bit count: 0..3 give 5..8, 7 gives 9, rest 8
  function automatic logic [3:0] uc_char_len(input logic [2:0] code);
    if (code == UC_SIZE_9)
      return 4'h9;
    if (code <= 3'h3)
      return 4'h5 + {1'b0, code};
    return 4'h8;
  endfunction

  function automatic logic [8:0] uc_mask(input logic [3:0] len);
    logic [8:0] m;
    m = 9'h000;
    for (int i = 0; i < 9; i++)
      if (i < int'(len))
        m[i] = 1'b1;
    return m;
  endfunction

  // parity bit to send, or to expect, for the given sense
  function automatic logic uc_parity(input logic [8:0] d,
                                     input logic [3:0] len,
                                     input logic odd);
    return (^(d & uc_mask(len))) ^ odd;
  endfunction
endpackage

// File: core/uc_core.sv
// serial transmitter/receiver core with baud generator and register port
`timescale 1ns/1ns
// Summary of operation
// - one buffered transmit character besides the shifting one, no gap.
// - receive shift register feeds a two-entry buffer read via data.
// - flag framing error, overrun and parity mismatch per character.
// - receiver accepts exactly the transmitter's frame formats.
// - transfer clock pin used only in synchronous mode, else undriven.
// - slave clock is synchronised; other modes use the baud generator.
// - five to nine data bits, one or two stop bits.
// - generate odd or even parity on send, check it on receive.
// - three requests: send complete, buffer empty, receive complete.
// - legacy mode keeps only one receive buffer level.
// - digital low-pass on receive line, false start bits rejected.
// - send and receive run at once on separate shift registers.
// - recovery units only for asynchronous receive; sync uses clock.
// - synchronous mode drives the clock as master or follows as slave.
// - double speed halves the bit period, asynchronous only.
// - start bit, data LSB first, parity, stops; line idles high.
// - baud down-counter reloads at zero or on low divisor write.
// - polarity zero changes data on rising edge, samples on falling.
// - framing, overrun and ninth bit stored with each buffered entry.
module uc_core (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic rxd,
  output logic txd,
  input wire logic transfer_clock_pin_in,
  output logic transfer_clock_pin_out,
  output logic transfer_clock_pin_oe,
  output logic irq_tx_complete,
  output logic irq_tx_empty,
  output logic irq_rx_complete
);
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] fmt;
    logic [7:0] mode;
    logic [11:0] baud;
    logic [11:0] brg;
    logic xck_o;
    logic xck_oe;
    logic xs1;
    logic xs2;
    logic xs3;
    logic [8:0] tx_buf;
    logic tx_full;
    logic [12:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [3:0] tx_tick;
    logic tx_busy;
    logic txd;
    logic tx_done;
    uc_pkg::uc_rx_t rx_st;
    logic [3:0] rx_tick;
    logic [3:0] rx_cnt;
    logic [11:0] rx_sh;
    logic [2:0] rx_samp;
    logic [1:0][11:0] mem;
    logic wp;
    logic rp;
    logic [1:0] fcnt;
    logic ovr;
    logic [7:0] rdata;
    logic irq_txc;
    logic irq_txe;
    logic irq_rxc;
  } uc_state_t;

  uc_state_t s;
  uc_state_t n;

  // ----------------------------------------------------------------
  // mode decode and timing strobes
  // ----------------------------------------------------------------
  logic sync_mode, master, pol, dbl, tick, rise_e, fall_e, chg_e, smp_e;
  logic tx_stb, tx_load, rx_line, pop, rx_fin;
  logic [3:0] bit_last, bit_mid, clen, flen;
  logic [1:0] depth;
  logic [11:0] head;

  assign sync_mode = s.fmt[uc_pkg::UC_F_SYNC];
  assign master = s.mode[uc_pkg::UC_M_MASTER];
  assign pol = s.fmt[uc_pkg::UC_F_POL];
  // double speed only counts in asynchronous mode
  assign dbl = s.ctl[uc_pkg::UC_C_DBL] && !sync_mode;
  assign bit_last = dbl ? uc_pkg::UC_DBL_LAST : uc_pkg::UC_NORM_LAST;
  assign bit_mid = dbl ? uc_pkg::UC_DBL_MID : uc_pkg::UC_NORM_MID;
  assign tick = s.brg == 12'h000;
  // master edges come from our own toggle, slave edges from the
  // synchronised pin; xs1 feeds only xs2 to keep metastability out
  assign rise_e = master ? (tick && !s.xck_o) : (s.xs2 && !s.xs3);
  assign fall_e = master ? (tick && s.xck_o) : (!s.xs2 && s.xs3);
  assign chg_e = pol ? fall_e : rise_e;
  assign smp_e = pol ? rise_e : fall_e;
  assign tx_stb = sync_mode ? chg_e : (tick && s.tx_tick == bit_last);
  // same length decode serves both directions so formats match
  assign clen = uc_pkg::uc_char_len(s.fmt[2:0]);
  assign flen = 4'h2 + clen + {3'h0, s.fmt[uc_pkg::UC_F_PAR]}
              + {3'h0, s.fmt[uc_pkg::UC_F_STOP2]};
  assign tx_load = tx_stb && !(s.tx_busy && s.tx_cnt != 4'h0)
                 && s.tx_full && s.ctl[uc_pkg::UC_C_TXEN];
  // majority of three baud samples is the low-pass filter
  assign rx_line = sync_mode ? rxd
                 : ((s.rx_samp[0] & s.rx_samp[1]) | (s.rx_samp[1] &
                    s.rx_samp[2]) | (s.rx_samp[0] & s.rx_samp[2]));
  assign depth = s.ctl[uc_pkg::UC_C_COMPAT] ? uc_pkg::UC_DEPTH_COMPAT
               : uc_pkg::UC_DEPTH;
  assign pop = rd && addr == uc_pkg::UC_ADR_DATA && s.fcnt != 2'h0;
  assign head = s.mem[s.rp];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [12:0] frame;
    logic [11:0] word;
    logic [8:0] rdat;
    logic rstb, fe, pe, push;
    logic [1:0] cnt_after;
    frame = 13'h1FFF;
    word = s.rx_sh;
    rdat = 9'h000;
    rstb = 1'b0;
    fe = 1'b0;
    pe = 1'b0;
    push = 1'b0;
    cnt_after = s.fcnt - {1'b0, pop};
    rx_fin = 1'b0;
    n = s;
    // register writes; status write of one clears send complete
    if (wr)
    begin
      unique case (addr)
        uc_pkg::UC_ADR_STAT: if (wdata[uc_pkg::UC_S_TXC]) n.tx_done = 1'b0;
        uc_pkg::UC_ADR_CTRL: n.ctl = wdata;
        uc_pkg::UC_ADR_FMT: n.fmt = wdata;
        uc_pkg::UC_ADR_MODE: n.mode = wdata;
        uc_pkg::UC_ADR_BAUDL: n.baud[7:0] = wdata;
        uc_pkg::UC_ADR_BAUDH: n.baud[11:8] = wdata[3:0];
        default: n.ctl = s.ctl;
      endcase
    end
    // baud down-counter; a low write restarts it with the new value
    if (wr && addr == uc_pkg::UC_ADR_BAUDL)
      n.brg = {s.baud[11:8], wdata};
    else if (tick)
      n.brg = s.baud;
    else
      n.brg = s.brg - 12'h001;
    // transfer clock: driven only as synchronous master
    n.xck_oe = sync_mode && master;
    if (sync_mode && master)
    begin
      if (tick)
        n.xck_o = !s.xck_o;
    end
    else
      n.xck_o = pol;
    n.xs1 = transfer_clock_pin_in;
    n.xs2 = s.xs1;
    n.xs3 = s.xs2;
    // send bit clock divider, 16 or 8 baud ticks per bit
    if (tick)
      n.tx_tick = (s.tx_tick == bit_last) ? 4'h0 : s.tx_tick + 4'h1;
    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    if (tx_stb)
    begin
      if (s.tx_busy && s.tx_cnt != 4'h0)
      begin
        n.txd = s.tx_sh[0];
        n.tx_sh = {1'b1, s.tx_sh[12:1]};
        n.tx_cnt = s.tx_cnt - 4'h1;
      end
      else if (tx_load)
      begin
        frame[0] = 1'b0;
        for (int i = 0; i < 9; i++)
          if (i < int'(clen))
            frame[i + 1] = s.tx_buf[i];
        if (s.fmt[uc_pkg::UC_F_PAR])
          frame[clen + 4'h1] = uc_pkg::uc_parity(s.tx_buf, clen,
                                 s.fmt[uc_pkg::UC_F_ODD]);
        n.txd = frame[0];
        n.tx_sh = {1'b1, frame[12:1]};
        n.tx_cnt = flen - 4'h1;
        n.tx_busy = 1'b1;
        n.tx_full = 1'b0;
      end
      else
      begin
        if (s.tx_busy)
          n.tx_done = 1'b1;
        n.tx_busy = 1'b0;
        n.txd = 1'b1;
      end
    end
    // a write is taken only while the buffer is free
    if (wr && addr == uc_pkg::UC_ADR_DATA && !s.tx_full)
    begin
      n.tx_buf = {s.ctl[uc_pkg::UC_C_TX9], wdata};
      n.tx_full = 1'b1;
    end
    // ----------------------------------------------------------------
    // receiver, independent of the send path
    // ----------------------------------------------------------------
    if (!sync_mode && tick)
      n.rx_samp = {s.rx_samp[1:0], rxd};
    unique case (s.rx_st)
      uc_pkg::UC_RX_IDLE:
      begin
        if (s.ctl[uc_pkg::UC_C_RXEN])
        begin
          if (sync_mode)
          begin
            if (smp_e && !rxd)
            begin
              n.rx_st = uc_pkg::UC_RX_DATA;
              n.rx_cnt = 4'h0;
            end
          end
          else if (tick && !rx_line)
          begin
            n.rx_st = uc_pkg::UC_RX_START;
            n.rx_tick = 4'h0;
          end
        end
      end
      uc_pkg::UC_RX_START:
      begin
        if (tick)
        begin
          if (s.rx_tick != bit_mid)
            n.rx_tick = s.rx_tick + 4'h1;
          else if (rx_line)
            n.rx_st = uc_pkg::UC_RX_IDLE;
          else
          begin
            n.rx_st = uc_pkg::UC_RX_DATA;
            n.rx_tick = 4'h0;
            n.rx_cnt = 4'h0;
          end
        end
      end
      uc_pkg::UC_RX_DATA:
      begin
        if (sync_mode)
          rstb = smp_e;
        else if (tick)
        begin
          rstb = s.rx_tick == bit_last;
          n.rx_tick = rstb ? 4'h0 : s.rx_tick + 4'h1;
        end
        if (rstb)
        begin
          word[s.rx_cnt] = rx_line;
          n.rx_sh = word;
          n.rx_cnt = s.rx_cnt + 4'h1;
          // only the first stop bit is checked
          if (s.rx_cnt == clen + {3'h0, s.fmt[uc_pkg::UC_F_PAR]})
          begin
            rx_fin = 1'b1;
            n.rx_st = uc_pkg::UC_RX_IDLE;
          end
        end
      end
      default: n.rx_st = uc_pkg::UC_RX_IDLE;
    endcase
    if (!s.ctl[uc_pkg::UC_C_RXEN])
      n.rx_st = uc_pkg::UC_RX_IDLE;
    // ----------------------------------------------------------------
    // receive buffer; errors travel with their character
    // ----------------------------------------------------------------
    rdat = word[8:0] & uc_pkg::uc_mask(clen);
    fe = !rx_line;
    pe = s.fmt[uc_pkg::UC_F_PAR] && (word[clen] != uc_pkg::uc_parity(
           rdat, clen, s.fmt[uc_pkg::UC_F_ODD]));
    if (pop)
      n.rp = !s.rp;
    if (rx_fin)
    begin
      if (cnt_after < depth)
      begin
        n.mem[s.wp] = {pe, s.ovr, fe, rdat};
        n.wp = !s.wp;
        n.ovr = 1'b0;
        push = 1'b1;
      end
      else
        n.ovr = 1'b1;
    end
    n.fcnt = cnt_after + {1'b0, push};
    // read data stand only in the cycle after the strobe
    n.rdata = 8'h00;
    if (rd && addr == uc_pkg::UC_ADR_DATA)
      n.rdata = head[7:0];
    else if (rd && addr == uc_pkg::UC_ADR_STAT)
      n.rdata = {1'b0, head[8] && s.fcnt != 2'h0, s.fcnt != 2'h0,
                 s.tx_done, !s.tx_full,
                 s.fcnt != 2'h0 ? {head[uc_pkg::UC_E_FE],
                 head[uc_pkg::UC_E_DOR], head[uc_pkg::UC_E_PE]}
                 : 3'h0};
    else if (rd && addr == uc_pkg::UC_ADR_CTRL)
      n.rdata = s.ctl;
    else if (rd && addr == uc_pkg::UC_ADR_FMT)
      n.rdata = s.fmt;
    else if (rd && addr == uc_pkg::UC_ADR_MODE)
      n.rdata = s.mode;
    else if (rd && addr == uc_pkg::UC_ADR_BAUDL)
      n.rdata = s.baud[7:0];
    else if (rd && addr == uc_pkg::UC_ADR_BAUDH)
      n.rdata = {4'h0, s.baud[11:8]};
    // requests follow next-state flags so they leave with them
    n.irq_txc = n.tx_done && n.ctl[uc_pkg::UC_C_IE_TXC];
    n.irq_txe = !n.tx_full && n.ctl[uc_pkg::UC_C_IE_TXE];
    n.irq_rxc = n.fcnt != 2'h0 && n.ctl[uc_pkg::UC_C_IE_RXC];
  end

  // state register
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '0;
      s.ctl <= uc_pkg::UC_CTRL_RST;
      s.fmt <= uc_pkg::UC_FMT_RST;
      s.mode <= uc_pkg::UC_MODE_RST;
      s.baud <= uc_pkg::UC_BAUD_RST;
      s.txd <= 1'b1;
      s.rx_samp <= 3'h7;
      s.rx_st <= uc_pkg::UC_RX_IDLE;
    end
    else
      s <= n;
  end

  assign rdata = s.rdata;
  assign txd = s.txd;
  assign transfer_clock_pin_out = s.xck_o;
  assign transfer_clock_pin_oe = s.xck_oe;
  assign irq_tx_complete = s.irq_txc;
  assign irq_tx_empty = s.irq_txe;
  assign irq_rx_complete = s.irq_rxc;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_load;
    tx_load;
  endsequence

  a_tx_buf_take: assert property (
    wr && addr == uc_pkg::UC_ADR_DATA && !s.tx_full |=>
      s.tx_full && s.tx_buf[7:0] == $past(wdata))
    else $error("send buffer did not take the write");
  a_start_low: assert property (s_load |=> !s.txd && s.tx_busy)
    else $error("frame did not open with a low start bit");
  a_back_to_back: assert property (
    s.tx_busy && s.tx_cnt == 4'h0 && tx_stb && s.tx_full &&
    s.ctl[uc_pkg::UC_C_TXEN] |=> s.tx_busy && !s.txd && !s.tx_full)
    else $error("gap between buffered frames");
  a_idle_high: assert property (
    !s.tx_busy && !$past(s.tx_busy) |-> s.txd)
    else $error("line not high while idle");
  a_tx_done_set: assert property (
    s.tx_busy && s.tx_cnt == 4'h0 && tx_stb && !tx_load |=> s.tx_done)
    else $error("send complete not flagged");
  a_brg_reload: assert property (
    wr && addr == uc_pkg::UC_ADR_BAUDL |=>
      s.brg == {s.baud[11:8], $past(wdata)})
    else $error("divisor low write did not reload counter");
  a_brg_down: assert property (
    !(wr && addr == uc_pkg::UC_ADR_BAUDL) && s.brg != 12'h000 |=>
      s.brg == $past(s.brg) - 12'h001)
    else $error("baud counter did not count down");
  a_xck_async: assert property (!sync_mode |=> !s.xck_oe)
    else $error("transfer clock driven in asynchronous mode");
  a_false_start: assert property (
    s.rx_st == uc_pkg::UC_RX_START && tick && s.rx_tick == bit_mid &&
    rx_line |=> s.rx_st == uc_pkg::UC_RX_IDLE)
    else $error("false start bit not rejected");
  a_fifo_bound: assert property (s.fcnt <= uc_pkg::UC_DEPTH)
    else $error("receive buffer over two entries");
  a_compat_single: assert property (
    s.ctl[uc_pkg::UC_C_COMPAT] && s.fcnt == 2'h1 && !pop && rx_fin |=>
      s.fcnt == 2'h1 && s.ovr)
    else $error("legacy mode buffered a second character");
endmodule

// File: tb/uc_peer.sv
// serial peer model facing the transmit and receive lines of the core
`timescale 1ns/1ns
module uc_peer (
  input wire logic sys_clk,
  input wire logic txd,
  output logic rxd,
  output logic tclk
);
  // ----------------------------------------------------------------
  // line state
  // ----------------------------------------------------------------
  // line idles high; the clock rests low outside synchronous frames
  initial
  begin
    rxd = 1'b1;
    tclk = 1'b0;
  end

  // ----------------------------------------------------------------
  // frame generator and frame capture
  // ----------------------------------------------------------------
  // one line level held for n system clocks
  task automatic put(input logic b, input int n);
    @(posedge sys_clk);
    rxd <= b;
    repeat (n - 1) @(posedge sys_clk);
  endtask

  // a bad stop is held just past its middle sample, so the tail of it
  // reads as a short false start that the receiver must reject
  task automatic send(input logic [8:0] d, input int len, input bit pe,
    input bit odd, input int stops, input bit bad_par, input bit bad_stop,
    input int bclk);
    logic p;
    p = odd ^ bad_par;
    for (int i = 0; i < len; i++)
      p = p ^ d[i];
    put(1'b0, bclk);
    for (int i = 0; i < len; i++)
      put(d[i], bclk);
    if (pe)
      put(p, bclk);
    for (int i = 0; i < stops; i++)
      if (bad_stop)
        put(1'b0, bclk / 2 + 2);
      else
        put(1'b1, bclk);
    put(1'b1, bclk);
  endtask

  // samples an 8N1 frame in bit middles; returns at the stop middle
  task automatic capture(output logic [7:0] d, output logic stp,
    output int wait_n, input int bclk);
    wait_n = 0;
    d = 8'h00;
    while (txd !== 1'b0 && wait_n < 2000)
    begin
      @(posedge sys_clk);
      wait_n++;
    end
    repeat (bclk / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bclk) @(posedge sys_clk);
      d[i] = txd;
    end
    repeat (bclk) @(posedge sys_clk);
    stp = txd;
  endtask

  // one synchronous frame each way as clock slave partner, polarity zero:
  // rxd changes with the rising pin edge, txd is taken at the falling one;
  // an eleventh clock lets the core close its frame, then the pin rests
  task automatic sync_xfer(input logic [7:0] d, output logic [9:0] got,
    input int half);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    got = 10'h000;
    for (int i = 0; i < 11; i++)
    begin
      @(posedge sys_clk);
      tclk <= 1'b1;
      rxd <= (i < 10) ? f[i] : 1'b1;
      repeat (half) @(posedge sys_clk);
      if (i < 10)
        got[i] = txd;
      tclk <= 1'b0;
      repeat (half - 1) @(posedge sys_clk);
    end
  endtask
endmodule

// File: tb/test_usart_core.sv
// self-checking testbench for the serial core
`timescale 1ns/1ns
module test_usart_core;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rxd, txd, tclk_in, tclk_out, tclk_oe;
  logic irq_txc, irq_txe, irq_rxc;
  int err_count = 0;
  int check_count = 0;

  // 10 MHz system clock
  always #50 sys_clk = ~sys_clk;

  uc_core i_dut (.sys_clk(sys_clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd),
    .transfer_clock_pin_in(tclk_in), .transfer_clock_pin_out(tclk_out),
    .transfer_clock_pin_oe(tclk_oe), .irq_tx_complete(irq_txc),
    .irq_tx_empty(irq_txe), .irq_rx_complete(irq_rxc));
  uc_peer i_peer (.sys_clk(sys_clk), .txd(txd), .rxd(rxd), .tclk(tclk_in));

  // ----------------------------------------------------------------
  // compare, bus and verdict tasks
  // ----------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
    input string msg);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    chk_byte({7'h00, got}, {7'h00, exp}, msg);
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask

  // status first: the pop moves the flags on with the entry
  task automatic rx_check(input logic [7:0] ed, input logic [7:0] es);
    logic [7:0] s;
    int n;
    n = 0;
    while (irq_rxc !== 1'b1 && n < 400)
    begin
      @(posedge sys_clk);
      n++;
    end
    bus_rd(uc_pkg::UC_ADR_STAT, s);
    chk_byte(s & 8'h67, es | 8'h20, "rx status");
    bus_rd(uc_pkg::UC_ADR_DATA, s);
    chk_byte(s, ed, "rx data");
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset values, an unmapped address, idle pins
  task automatic t_reset();
    logic [2:0] a [5] = '{3'h2, 3'h3, 3'h6, 3'h7, 3'h1};
    logic [7:0] e [5] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h08};
    logic [7:0] d;
    for (int i = 0; i < 5; i++)
    begin
      bus_rd(a[i], d);
      chk_byte(d, e[i], "reset value");
    end
    chk_bit(txd, 1'b1, "idle line");
    chk_bit(tclk_oe, 1'b0, "clock pin undriven");
  endtask

  // two frames back to back while a frame arrives at the same time
  task automatic t_tx_duplex();
    logic [7:0] a, b;
    logic s1, s2;
    int w1, w2, n;
    bus_wr(uc_pkg::UC_ADR_CTRL, 8'hE3);
    fork
      begin
        i_peer.capture(a, s1, w1, 16);
        i_peer.capture(b, s2, w2, 16);
      end
      i_peer.send(9'h03C, 8, 0, 0, 1, 0, 0, 16);
      begin
        bus_wr(uc_pkg::UC_ADR_DATA, 8'hA5);
        repeat (3) @(posedge sys_clk);
        n = 0;
        while (irq_txe !== 1'b1 && n < 100)
        begin
          @(posedge sys_clk);
          n++;
        end
        bus_wr(uc_pkg::UC_ADR_DATA, 8'h3B);
        repeat (2) @(posedge sys_clk);
        chk_bit(irq_txe, 1'b0, "empty clears on write");
      end
    join
    chk_byte(a, 8'hA5, "first frame");
    chk_byte(b, 8'h3B, "second frame");
    chk_bit(s1 & s2, 1'b1, "stop bits");
    chk_bit(logic'(w2 <= 16), 1'b1, "gap between frames");
    rx_check(8'h3C, 8'h00);
    n = 0;
    while (irq_txc !== 1'b1 && n < 60)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk_bit(irq_txc, 1'b1, "send complete");
    bus_wr(uc_pkg::UC_ADR_STAT, 8'h10);
    repeat (2) @(posedge sys_clk);
    chk_bit(irq_txc, 1'b0, "send complete cleared");
  endtask

  // lengths, parity senses, stop counts, the ninth bit and the parity and framing error flags
  task automatic t_formats();
    logic [7:0] f [6] = '{8'h20, 8'h71, 8'h02, 8'h37, 8'h23, 8'h03};
    logic [8:0] d [6] = '{9'h015, 9'h02A, 9'h055, 9'h1A5, 9'h05A, 9'h0C3};
    int ln [6] = '{5, 6, 7, 9, 8, 8};
    logic [7:0] es [6] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h01, 8'h04};
    for (int i = 0; i < 6; i++)
    begin
      bus_wr(uc_pkg::UC_ADR_FMT, f[i]);
      i_peer.send(d[i], ln[i], f[i][5], f[i][4], f[i][6] ? 2 : 1, i == 4,
        i == 5, 16);
      rx_check(d[i][7:0], es[i]);
    end
    repeat (200) @(posedge sys_clk);
    chk_bit(irq_rxc, 1'b0, "false start rejected");
    bus_wr(uc_pkg::UC_ADR_FMT, 8'h03);
  endtask

  // two-level buffer, then the single level of legacy mode
  task automatic t_buffer();
    i_peer.send(9'h011, 8, 0, 0, 1, 0, 0, 16);
    i_peer.send(9'h022, 8, 0, 0, 1, 0, 0, 16);
    rx_check(8'h11, 8'h00);
    rx_check(8'h22, 8'h00);
    bus_wr(uc_pkg::UC_ADR_CTRL, 8'hEB);
    i_peer.send(9'h033, 8, 0, 0, 1, 0, 0, 16);
    i_peer.send(9'h044, 8, 0, 0, 1, 0, 0, 16);
    rx_check(8'h33, 8'h00);
    i_peer.send(9'h055, 8, 0, 0, 1, 0, 0, 16);
    rx_check(8'h55, 8'h02);
    repeat (2) @(posedge sys_clk);
    chk_bit(irq_rxc, 1'b0, "buffer drained");
    bus_wr(uc_pkg::UC_ADR_CTRL, 8'hE3);
  endtask

  // half the bit period in double speed
  task automatic t_double();
    logic [7:0] a;
    logic s;
    int w;
    bus_wr(uc_pkg::UC_ADR_CTRL, 8'hE7);
    fork
      i_peer.capture(a, s, w, 8);
      bus_wr(uc_pkg::UC_ADR_DATA, 8'h96);
    join
    chk_byte(a, 8'h96, "double speed frame");
    repeat (20) @(posedge sys_clk);
    bus_wr(uc_pkg::UC_ADR_CTRL, 8'hE3);
  endtask

  // master clock from divisor 3 toggles every 4 clocks, then released
  task automatic t_sync();
    logic prev;
    int n;
    bus_wr(uc_pkg::UC_ADR_BAUDH, 8'h00);
    bus_wr(uc_pkg::UC_ADR_BAUDL, 8'h03);
    bus_wr(uc_pkg::UC_ADR_FMT, 8'h83);
    bus_wr(uc_pkg::UC_ADR_MODE, 8'h01);
    repeat (4) @(posedge sys_clk);
    chk_bit(tclk_oe, 1'b1, "master drives clock");
    n = 0;
    prev = tclk_out;
    repeat (40)
    begin
      @(posedge sys_clk);
      if (tclk_out !== prev)
        n++;
      prev = tclk_out;
    end
    chk_bit(logic'(n >= 9 && n <= 11), 1'b1, "clock rate");
    bus_wr(uc_pkg::UC_ADR_FMT, 8'h03);
    repeat (3) @(posedge sys_clk);
    chk_bit(tclk_oe, 1'b0, "async releases pin");
  endtask

  // clock slave: the peer clocks one frame each way at the same time
  task automatic t_slave();
    logic [9:0] g;
    bus_wr(uc_pkg::UC_ADR_MODE, 8'h00);
    bus_wr(uc_pkg::UC_ADR_FMT, 8'h83);
    bus_wr(uc_pkg::UC_ADR_DATA, 8'hC6);
    chk_bit(tclk_oe, 1'b0, "slave leaves pin");
    i_peer.sync_xfer(8'h5A, g, 8);
    chk_byte(g[8:1], 8'hC6, "sync slave send");
    chk_bit(g[9] & ~g[0], 1'b1, "sync framing");
    rx_check(8'h5A, 8'h00);
    bus_wr(uc_pkg::UC_ADR_FMT, 8'h03);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    t_tx_duplex();
    t_formats();
    t_buffer();
    t_double();
    t_sync();
    t_slave();
    print_verdict();
  end

  // the whole run needs well under 10000 cycles
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
